// file: verilog/cfls_map.vh
// constants of the loop sequencer: opcodes, sizes, offsets, fields, resets
`ifndef CFLS_MAP_VH
`define CFLS_MAP_VH

`define CFLS_OP_W            8
`define CFLS_OP_LOOP_OPEN    8'h04
`define CFLS_OP_LOOP_CLOSE   8'h05
`define CFLS_OP_OPEN_BRKTRK  8'h06
`define CFLS_OP_OPEN_NOINDEX 8'h07
`define CFLS_OP_LOOP_CONT    8'h08
`define CFLS_OP_LOOP_BREAK   8'h09

`define CFLS_PIX             16
`define CFLS_DEPTH           8
`define CFLS_SP_W            4
`define CFLS_ADDR_W          16
`define CFLS_POP_W           3
`define CFLS_NCONST          32
`define CFLS_SEL_W           5

`define CFLS_TRIP_LSB        0
`define CFLS_INIT_LSB        8
`define CFLS_STEP_LSB        16
`define CFLS_FIELD_W         8

`define CFLS_CONST_OFF       12'h000
`define CFLS_STATUS_OFF      12'h080
`define CFLS_MASK_OFF        12'h084
`define CFLS_INDEX_OFF       12'h088

`define CFLS_ST_SP_LSB       0
`define CFLS_ST_NEST_LSB     4
`define CFLS_ST_BRKCNT_LSB   8
`define CFLS_ST_OVF_BIT      16
`define CFLS_ST_UNF_BIT      17

`define CFLS_CONST_RST       24'h00_0000
`define CFLS_MASK_RST        16'hFFFF

`endif

// file: verilog/cfls_loop_sequencer.v
// loop-control part of the control-flow sequencer, with AHB-Lite regs
`timescale 1ns/1ps
`include "cfls_map.vh"

module cfls_loop_sequencer (
    input  wire                        sys_clk,
    input  wire                        rst_n,
    input  wire                        hsel,
    input  wire [11:0]                 haddr,
    input  wire [1:0]                  htrans,
    input  wire                        hwrite,
    input  wire [2:0]                  hsize,
    input  wire                        hready,
    input  wire [31:0]                 hwdata,
    output reg  [31:0]                 hrdata,
    output wire                        hreadyout,
    output wire                        hresp,
    input  wire                        wave_start,
    input  wire [`CFLS_PIX-1:0]        wave_mask,
    input  wire                        instr_valid,
    input  wire [`CFLS_OP_W-1:0]       flow_opcode_field,
    input  wire [`CFLS_ADDR_W-1:0]     target_addr,
    input  wire [`CFLS_POP_W-1:0]      pop_count,
    input  wire [`CFLS_SEL_W-1:0]      loop_constant_select,
    input  wire [`CFLS_PIX-1:0]        cond_mask,
    output reg                         instr_done,
    output reg                         jump,
    output reg  [`CFLS_ADDR_W-1:0]     jump_target,
    output reg  [`CFLS_PIX-1:0]        active_mask,
    output reg  [`CFLS_FIELD_W-1:0]    loop_index_register
);

    localparam PW = `CFLS_PIX;
    localparam FW = `CFLS_FIELD_W;
    localparam SW = `CFLS_SP_W;

    // constant bank and live loop state
    reg [3*FW-1:0] lconst [0:`CFLS_NCONST-1];
    reg [FW-1:0]   cnt;
    reg [FW-1:0]   step;
    reg [PW-1:0]   lmask;
    reg [PW-1:0]   brk;
    reg [PW-1:0]   cont;
    reg [SW-1:0]   base;
    reg            noidx;
    reg [FW-1:0]   brk_count;
    reg [SW-1:0]   nest;
    reg [SW-1:0]   sp;
    reg            ovf;
    reg            unf;

    // stack, one field per array
    reg [PW-1:0]   s_mask   [0:`CFLS_DEPTH-1];
    reg [FW-1:0]   s_cnt    [0:`CFLS_DEPTH-1];
    reg [FW-1:0]   s_idx    [0:`CFLS_DEPTH-1];
    reg [FW-1:0]   s_step   [0:`CFLS_DEPTH-1];
    reg [PW-1:0]   s_lmask  [0:`CFLS_DEPTH-1];
    reg [PW-1:0]   s_brk    [0:`CFLS_DEPTH-1];
    reg [PW-1:0]   s_cont   [0:`CFLS_DEPTH-1];
    reg [SW-1:0]   s_base   [0:`CFLS_DEPTH-1];
    reg            s_noidx  [0:`CFLS_DEPTH-1];
    reg [FW-1:0]   s_brkcnt [0:`CFLS_DEPTH-1];

    // bus data-phase state
    reg            dp_wr;
    reg [11:0]     dp_addr;

    integer i;

    function [SW-1:0] sp_sub;
        input [SW-1:0] a;
        input [SW-1:0] n;
        begin
            sp_sub = (n > a) ? {SW{1'b0}} : a - n;
        end
    endfunction

    function [FW-1:0] cfield;
        input [3*FW-1:0] k;
        input [1:0]      which;
        begin
            cfield = k[which*FW +: FW];
        end
    endfunction

    // instruction decode
    wire is_open  = instr_valid &&
                    (flow_opcode_field == `CFLS_OP_LOOP_OPEN ||
                     flow_opcode_field == `CFLS_OP_OPEN_BRKTRK ||
                     flow_opcode_field == `CFLS_OP_OPEN_NOINDEX);
    wire is_ni    = flow_opcode_field == `CFLS_OP_OPEN_NOINDEX;
    wire is_trk   = flow_opcode_field == `CFLS_OP_OPEN_BRKTRK;
    wire is_close = instr_valid &&
                    flow_opcode_field == `CFLS_OP_LOOP_CLOSE;
    wire is_cont  = instr_valid &&
                    flow_opcode_field == `CFLS_OP_LOOP_CONT;
    wire is_brk   = instr_valid &&
                    flow_opcode_field == `CFLS_OP_LOOP_BREAK;

    wire [3*FW-1:0] kc   = lconst[loop_constant_select];
    wire [FW-1:0]   trip = cfield(kc, 2'd0);
    wire [FW-1:0]   kini = cfield(kc, 2'd1);
    wire [FW-1:0]   kstp = cfield(kc, 2'd2);

    // zero trip count fails every pixel
    wire [PW-1:0] open_pass = (trip == {FW{1'b0}}) ? {PW{1'b0}}
                              : (active_mask & cond_mask);
    wire          open_skip = open_pass == {PW{1'b0}};
    wire [PW-1:0] hit       = active_mask & cond_mask;
    wire [PW-1:0] cut       = active_mask & ~hit;
    wire          all_off   = cut == {PW{1'b0}};
    wire [FW-1:0] cnt_dec   = cnt - 1'b1;
    wire [PW-1:0] survive   = lmask & ~brk & cond_mask;
    wire          again     = (cnt_dec != {FW{1'b0}}) &&
                              (survive != {PW{1'b0}});
    wire [SW-1:0] pop_n     = {{(SW-`CFLS_POP_W){1'b0}}, pop_count};
    wire [SW-1:0] skip_sp   = sp_sub(sp, pop_n);
    wire [SW-1:0] top_sp    = sp_sub(sp, {{(SW-1){1'b0}}, 1'b1});
    wire [2:0]    top       = top_sp[2:0];
    wire [2:0]    sk        = skip_sp[2:0];
    wire          full      = sp == `CFLS_DEPTH;

    // loop sequencing
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            active_mask         <= `CFLS_MASK_RST;
            loop_index_register <= {FW{1'b0}};
            cnt       <= {FW{1'b0}};
            step      <= {FW{1'b0}};
            lmask     <= {PW{1'b0}};
            brk       <= {PW{1'b0}};
            cont      <= {PW{1'b0}};
            base      <= {SW{1'b0}};
            noidx     <= 1'b0;
            brk_count <= {FW{1'b0}};
            nest      <= {SW{1'b0}};
            sp        <= {SW{1'b0}};
            ovf       <= 1'b0;
            unf       <= 1'b0;
            jump        <= 1'b0;
            jump_target <= {`CFLS_ADDR_W{1'b0}};
            instr_done  <= 1'b0;
            for (i = 0; i < `CFLS_DEPTH; i = i + 1) begin
                s_mask[i]   <= {PW{1'b0}};
                s_cnt[i]    <= {FW{1'b0}};
                s_idx[i]    <= {FW{1'b0}};
                s_step[i]   <= {FW{1'b0}};
                s_lmask[i]  <= {PW{1'b0}};
                s_brk[i]    <= {PW{1'b0}};
                s_cont[i]   <= {PW{1'b0}};
                s_base[i]   <= {SW{1'b0}};
                s_noidx[i]  <= 1'b0;
                s_brkcnt[i] <= {FW{1'b0}};
            end
        end else begin
            instr_done  <= instr_valid;
            jump        <= 1'b0;
            jump_target <= target_addr;
            // sticky error flags: hardware set wins over software clear
            if (dp_wr && dp_addr == `CFLS_STATUS_OFF) begin
                ovf <= ~hwdata[`CFLS_ST_OVF_BIT] & ovf;
                unf <= ~hwdata[`CFLS_ST_UNF_BIT] & unf;
            end
            if (wave_start) begin
                active_mask <= wave_mask;
                sp          <= {SW{1'b0}};
                nest        <= {SW{1'b0}};
            end else if (is_open) begin
                if (open_skip) begin
                    jump <= 1'b1;
                    if (pop_n != {SW{1'b0}}) begin
                        if (pop_n > sp)
                            unf <= 1'b1;
                        sp          <= skip_sp;
                        active_mask <= s_mask[sk];
                    end
                end else if (full) begin
                    ovf <= 1'b1;
                end else begin
                    // save outer state, then set up the new loop
                    s_mask[sp[2:0]]   <= active_mask;
                    s_cnt[sp[2:0]]    <= cnt;
                    s_idx[sp[2:0]]    <= loop_index_register;
                    s_step[sp[2:0]]   <= step;
                    s_lmask[sp[2:0]]  <= lmask;
                    s_brk[sp[2:0]]    <= brk;
                    s_cont[sp[2:0]]   <= cont;
                    s_base[sp[2:0]]   <= base;
                    s_noidx[sp[2:0]]  <= noidx;
                    s_brkcnt[sp[2:0]] <= brk_count;
                    sp          <= sp + 1'b1;
                    base        <= sp + 1'b1;
                    active_mask <= open_pass;
                    lmask       <= open_pass;
                    cnt         <= trip;
                    step        <= kstp;
                    brk         <= {PW{1'b0}};
                    cont        <= {PW{1'b0}};
                    noidx       <= is_ni;
                    if (!is_ni)
                        loop_index_register <= kini;
                    if (is_trk) begin
                        brk_count <= {FW{1'b0}};
                        nest      <= nest + 1'b1;
                    end
                end
            end else if (is_brk || is_cont) begin
                active_mask <= cut;
                if (is_brk) begin
                    brk       <= brk | hit;
                    brk_count <= brk_count + {{(FW-1){1'b0}}, |hit};
                end else begin
                    cont <= cont | hit;
                end
                if (all_off) begin
                    jump <= 1'b1;
                    sp   <= base;
                end // else fall through
            end else if (is_close) begin
                cnt <= cnt_dec;
                if (again) begin
                    jump        <= 1'b1;
                    active_mask <= lmask & ~brk;
                    cont        <= {PW{1'b0}};
                    if (!noidx)
                        loop_index_register <= loop_index_register
                                               + step;
                end else begin
                    // exit: one entry back, outer loop resumes
                    sp          <= top_sp;
                    if (sp == {SW{1'b0}})
                        unf <= 1'b1;
                    active_mask <= s_mask[top];
                    cnt         <= s_cnt[top];
                    step        <= s_step[top];
                    lmask       <= s_lmask[top];
                    brk         <= s_brk[top];
                    cont        <= s_cont[top];
                    base        <= s_base[top];
                    noidx       <= s_noidx[top];
                    brk_count   <= s_brkcnt[top];
                    nest        <= sp_sub(nest, {{(SW-1){1'b0}}, 1'b1});
                    if (!noidx)
                        loop_index_register <= s_idx[top];
                end
            end
        end
    end

    // AHB-Lite slave: zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    wire addr_ok = hsel && hready && htrans[1];

    function [31:0] rd_word;
        input [11:0] a;
        begin
            rd_word = 32'h0000_0000;
            if (a < `CFLS_STATUS_OFF)
                rd_word = {8'h00, lconst[a[6:2]]};
            else if (a == `CFLS_STATUS_OFF)
                rd_word = {14'h0000, unf, ovf, brk_count,
                           nest, sp};
            else if (a == `CFLS_MASK_OFF)
                rd_word = {16'h0000, active_mask};
            else if (a == `CFLS_INDEX_OFF)
                rd_word = {24'h00_0000, loop_index_register};
        end
    endfunction

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dp_wr   <= 1'b0;
            dp_addr <= 12'h000;
            hrdata  <= 32'h0000_0000;
            for (i = 0; i < `CFLS_NCONST; i = i + 1)
                lconst[i] <= `CFLS_CONST_RST;
        end else begin
            dp_wr   <= addr_ok && hwrite;
            dp_addr <= {haddr[11:2], 2'b00};
            if (addr_ok && !hwrite)
                hrdata <= rd_word({haddr[11:2], 2'b00});
            if (dp_wr && dp_addr < `CFLS_STATUS_OFF)
                lconst[dp_addr[6:2]] <= hwdata[23:0];
        end
    end

endmodule // cfls_loop_sequencer

// file: tb/cfls_loop_sequencer_chk.sv
// port assertions for the loop sequencer
`timescale 1ns/1ps
`include "cfls_map.vh"

module cfls_chk (
    input wire        sys_clk,
    input wire        rst_n,
    input wire        wave_start,
    input wire        instr_valid,
    input wire [7:0]  flow_opcode_field,
    input wire [15:0] target_addr,
    input wire [15:0] cond_mask,
    input wire        instr_done,
    input wire        jump,
    input wire [15:0] jump_target,
    input wire [15:0] active_mask
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire take = instr_valid && !wave_start;
    wire brk  = take && flow_opcode_field == `CFLS_OP_LOOP_BREAK;
    wire cont = take && flow_opcode_field == `CFLS_OP_LOOP_CONT;
    wire cls  = take && flow_opcode_field == `CFLS_OP_LOOP_CLOSE;
    wire opn  = take && flow_opcode_field == `CFLS_OP_LOOP_OPEN;
    wire oth  = take && (flow_opcode_field < 8'h04 ||
                         flow_opcode_field > 8'h09);

    break_clears_a: assert property (
        brk |=> (active_mask & $past(cond_mask)) == 16'h0000)
        else $error("break left a true pixel active");
    cont_clears_a: assert property (
        cont |=> (active_mask & $past(cond_mask)) == 16'h0000)
        else $error("continue left a true pixel active");
    all_off_jump_a: assert property (
        brk || cont |=> jump == (active_mask == 16'h0000))
        else $error("break or continue jump wrong");
    break_decode_a: assert property (
        brk |=> instr_done && jump_target == $past(target_addr))
        else $error("break not answered");
    cont_decode_a: assert property (
        cont |=> instr_done && jump_target == $past(target_addr))
        else $error("continue not answered");
    close_fail_a: assert property (
        cls && cond_mask == 16'h0000 |=> instr_done && !jump)
        else $error("close jumped with no survivor");
    close_live_a: assert property (
        cls |=> !jump || active_mask != 16'h0000)
        else $error("close jumped with all pixels off");
    open_fail_a: assert property (
        opn |=> jump || (active_mask & ~$past(cond_mask)) == 16'h0000)
        else $error("open kept a failing pixel");
    other_op_a: assert property (
        oth |=> !jump && active_mask == $past(active_mask))
        else $error("unknown opcode acted");
    idle_quiet_a: assert property (
        !instr_valid |=> !instr_done && !jump)
        else $error("answer without instruction");
endmodule // cfls_chk

bind cfls_loop_sequencer cfls_chk cfls_chk_i (.sys_clk(sys_clk),
    .rst_n(rst_n), .wave_start(wave_start), .instr_valid(instr_valid),
    .flow_opcode_field(flow_opcode_field), .target_addr(target_addr),
    .cond_mask(cond_mask), .instr_done(instr_done), .jump(jump),
    .jump_target(jump_target), .active_mask(active_mask));

// file: tb/cfls_flow_src.sv
// program memory and execution units issuing control-flow words
`timescale 1ns/1ps

module cfls_flow_src (
    input  wire        sys_clk,
    output reg         wave_start,
    output reg  [15:0] wave_mask,
    output reg         instr_valid,
    output reg  [7:0]  flow_opcode_field,
    output reg  [15:0] target_addr,
    output reg  [2:0]  pop_count,
    output reg  [4:0]  loop_constant_select,
    output reg  [15:0] cond_mask
);
    initial begin
        {wave_start, wave_mask, instr_valid} = 18'h0;
        {flow_opcode_field, target_addr, pop_count} = 27'h0;
        {loop_constant_select, cond_mask} = 21'h0;
    end
    // released fields show the inverse, not a stale value
    task issue(input [7:0] op, input [15:0] tg, input [2:0] p,
               input [4:0] sl, input [15:0] c);
        begin
            @(posedge sys_clk);
            instr_valid <= 1'b1;
            flow_opcode_field <= op;
            target_addr <= tg;
            pop_count <= p;
            loop_constant_select <= sl;
            cond_mask <= c;
            @(posedge sys_clk);
            instr_valid <= 1'b0;
            flow_opcode_field <= ~op;
            target_addr <= ~tg;
            pop_count <= ~p;
            loop_constant_select <= ~sl;
            cond_mask <= ~c;
            #1;
        end
    endtask
    task wave(input [15:0] m);
        begin
            @(posedge sys_clk);
            wave_start <= 1'b1;
            wave_mask <= m;
            @(posedge sys_clk);
            wave_start <= 1'b0;
            wave_mask <= ~m;
            #1;
        end
    endtask
endmodule // cfls_flow_src

// file: tb/tb_top.sv
// self-checking bench for the loop sequencer
`timescale 1ns/1ps
`include "cfls_map.vh"

module tb_top;
    reg         sys_clk, rst_n, hwrite;
    reg  [11:0] haddr;
    reg  [1:0]  htrans;
    reg  [31:0] hwdata, v;
    reg  [15:0] seed, r;
    reg  [7:0]  ini [0:3];
    reg  [7:0]  stp [0:3];
    wire [31:0] hrdata;
    wire        hreadyout, hresp, wave_start, instr_valid, instr_done, jump;
    wire [15:0] wave_mask, target_addr, cond_mask, jump_target, active_mask;
    wire [7:0]  flow_opcode_field, loop_index_register;
    wire [4:0]  loop_constant_select;
    wire [2:0]  pop_count;
    integer     failures, checks_done, i;

    cfls_loop_sequencer cfls_loop_sequencer_i (.sys_clk(sys_clk),
        .rst_n(rst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .wave_start(wave_start), .wave_mask(wave_mask),
        .instr_valid(instr_valid), .flow_opcode_field(flow_opcode_field),
        .target_addr(target_addr), .pop_count(pop_count),
        .loop_constant_select(loop_constant_select),
        .cond_mask(cond_mask), .instr_done(instr_done), .jump(jump),
        .jump_target(jump_target), .active_mask(active_mask),
        .loop_index_register(loop_index_register));
    cfls_flow_src src_i (.sys_clk(sys_clk), .wave_start(wave_start),
        .wave_mask(wave_mask), .instr_valid(instr_valid),
        .flow_opcode_field(flow_opcode_field), .target_addr(target_addr),
        .pop_count(pop_count), .loop_constant_select(loop_constant_select),
        .cond_mask(cond_mask));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    function [15:0] lfsr(input [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function [7:0] trp(input [1:0] k);
        trp = (k == 2'd3) ? 8'd1 : (k == 2'd0) ? 8'd0 : {6'd0, k} + 8'd2;
    endfunction
    task chk(input [8*6:1] n, input [31:0] e, input [31:0] g);
        begin
            checks_done = checks_done + 1;
            if (g !== e) begin
                failures = failures + 1;
                $display("[FAIL] %0s expected %h seen %h", n, e, g);
            end
        end
    endtask
    task ahb(input w, input [11:0] ad, input [31:0] wd, output [31:0] rd);
        begin
            @(posedge sys_clk);
            htrans <= 2'b10;
            haddr <= ad;
            hwrite <= w;
            do @(posedge sys_clk); while (hreadyout !== 1'b1);
            htrans <= 2'b00;
            hwdata <= wd;
            do @(posedge sys_clk); while (hreadyout !== 1'b1);
            rd = hrdata;
        end
    endtask
    task rdc(input [11:0] ad, input [31:0] m, input [31:0] e);
        begin
            ahb(1'b0, ad, 32'h0, v);
            chk("regrd", e, v & m);
            chk("hresp", 32'h0, hresp);
        end
    endtask
    task ins(input [7:0] op, input [15:0] tg, input [4:0] sl,
             input [15:0] c, input ej, input [15:0] em, input [7:0] ei);
        begin
            seed = lfsr(seed);
            src_i.issue(op, tg, (op == 8'h05 || op > 8'h07) ? seed[2:0]
                        : 3'd0, sl, c);
            chk("done", 32'h1, instr_done);
            chk("jump", ej, jump);
            chk("target", tg, jump_target);
            chk("mask", em, active_mask);
            chk("index", ei, loop_index_register);
        end
    endtask
    task results;
        begin
            $display("checks %0d failures %0d", checks_done, failures);
            if (failures == 0 && checks_done > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    initial begin
        #100000;
        failures = failures + 1;
        results;
    end

    initial begin
        failures = 0;
        checks_done = 0;
        seed = 16'd61353;
        rst_n = 1'b0;
        {hwrite, haddr, htrans, hwdata, v} = 79'h0;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        ahb(1'b1, 12'h0FC, 32'hFFFFFFFF, v);
        rdc(12'h0FC, 32'hFFFFFFFF, 32'h0);
        rdc(`CFLS_STATUS_OFF, 32'hFFFFFFFF, 32'h0);
        rdc(`CFLS_MASK_OFF, 32'hFFFFFFFF, 32'hFFFF);
        rdc(`CFLS_INDEX_OFF, 32'hFFFFFFFF, 32'h0);
        for (i = 0; i < 4; i = i + 1) begin
            seed = lfsr(seed);
            ini[i] = seed[7:0];
            stp[i] = seed[15:8];
            ahb(1'b1, {i[9:0], 2'b00}, {8'hA5, seed, trp(i[1:0])}, v);
            rdc({i[9:0], 2'b00}, 32'hFFFFFFFF,
                {8'h00, seed, trp(i[1:0])});
        end
        $display("test registers done");
        src_i.wave(16'hFFFF);
        ins(`CFLS_OP_LOOP_OPEN, 16'h0040, 5'd1, 16'hFFFF, 1'b0, 16'hFFFF,
            ini[1]);
        ins(`CFLS_OP_LOOP_CLOSE, 16'h0011, 5'd1, 16'hFFFF, 1'b1, 16'hFFFF,
            ini[1] + stp[1]);
        ins(`CFLS_OP_LOOP_CLOSE, 16'h0011, 5'd1, 16'hFFFF, 1'b1, 16'hFFFF,
            ini[1] + stp[1] + stp[1]);
        ins(`CFLS_OP_LOOP_CLOSE, 16'h0011, 5'd1, 16'hFFFF, 1'b0, 16'hFFFF,
            8'h00);
        rdc(`CFLS_STATUS_OFF, 32'h0000000F, 32'h0);
        for (i = 0; i < 3; i = i + 1)
            ins((i == 0) ? 8'h04 : 8'h05 + i[7:0], 16'h0080, 5'd0,
                16'hFFFF, 1'b1, 16'hFFFF, 8'h00);
        $display("test counted loop done");
        seed = lfsr(seed);
        r = (seed & 16'h3FFF) | 16'h0001;
        ins(`CFLS_OP_OPEN_BRKTRK, 16'h0100, 5'd2, 16'hFFFF, 1'b0, 16'hFFFF,
            ini[2]);
        ins(`CFLS_OP_LOOP_BREAK, 16'h0105, 5'd0, r, 1'b0, ~r,
            ini[2]);
        ins(`CFLS_OP_LOOP_CONT, 16'h0105, 5'd0, 16'h8000, 1'b0,
            ~r & 16'h7FFF, ini[2]);
        rdc(`CFLS_STATUS_OFF, 32'h0000FFF0, 32'h00000110);
        ins(`CFLS_OP_LOOP_CLOSE, 16'h0101, 5'd2, 16'hFFFF, 1'b1, ~r,
            ini[2] + stp[2]);
        ins(`CFLS_OP_LOOP_BREAK, 16'h0105, 5'd0, 16'hFFFF, 1'b1, 16'h0,
            ini[2] + stp[2]);
        ins(`CFLS_OP_LOOP_CLOSE, 16'h0101, 5'd2, 16'hFFFF, 1'b0, 16'hFFFF,
            8'h00);
        rdc(`CFLS_STATUS_OFF, 32'h0000000F, 32'h0);
        $display("test break done");
        ins(`CFLS_OP_LOOP_OPEN, 16'h0200, 5'd1, 16'hFFFF, 1'b0, 16'hFFFF,
            ini[1]);
        ins(`CFLS_OP_LOOP_OPEN, 16'h0210, 5'd3, 16'hFFFF, 1'b0, 16'hFFFF,
            ini[3]);
        ins(`CFLS_OP_LOOP_CLOSE, 16'h0202, 5'd3, 16'h0, 1'b0, 16'hFFFF,
            ini[1]);
        ins(`CFLS_OP_OPEN_NOINDEX, 16'h0210, 5'd3, 16'hFFFF, 1'b0,
            16'hFFFF, ini[1]);
        ins(`CFLS_OP_LOOP_CLOSE, 16'h0202, 5'd3, 16'hFFFF, 1'b0, 16'hFFFF,
            ini[1]);
        ins(`CFLS_OP_LOOP_CLOSE, 16'h0201, 5'd1, 16'h0, 1'b0, 16'hFFFF,
            8'h00);
        $display("test nesting done");
        for (i = 0; i < 4; i = i + 1)
            ins({i[2:0], 5'h00}, 16'h0300, 5'd1, 16'h00FF, 1'b0, 16'hFFFF,
                8'h00);
        ins(`CFLS_OP_LOOP_OPEN, 16'h0310, 5'd1, 16'h00FF, 1'b0, 16'h00FF,
            ini[1]);
        src_i.issue(`CFLS_OP_LOOP_OPEN, 16'h0320, 3'd1, 5'd0, 16'hFFFF);
        chk("jump", 32'h1, jump);
        chk("mask", 32'hFFFF, active_mask);
        rdc(`CFLS_STATUS_OFF, 32'h0000000F, 32'h0);
        for (i = 0; i < 9; i = i + 1)
            src_i.issue(`CFLS_OP_LOOP_OPEN, 16'h0400, 3'd0, 5'd1, 16'hFFFF);
        rdc(`CFLS_STATUS_OFF, 32'h00010000, 32'h00010000);
        src_i.wave(16'hFFFF);
        ahb(1'b1, `CFLS_STATUS_OFF, 32'h00010000, v);
        rdc(`CFLS_STATUS_OFF, 32'h0001000F, 32'h0);
        $display("test refusal done");
        results;
    end
endmodule // tb_top
